// File: pkg/cls_pkg.sv
/*
  constants, codes and types of the custom logic step timer block.
  assumes a 25 MHz system clock and a 2 ms processing tick.
*/
// Contract
// - set-priority: input one wins, both off holds
// - reset-priority: input two wins, both off holds
// - timer type codes zero to five select behaviour
// - on-delay: on after period, off immediately
// - off-delay: on immediately, off after period
// - one-shot pulse; retriggerable restarts full pulse
// - pulse train alternates period on, period off
// - time setting zero to 60000 hundredths, seconds
// - counter target equals raw hundredth setting; the code uses the setting times five 2 ms ticks
// - ten step results, selectable as step inputs
// - results leave only through five channels; the code also returns them in the status register
// - channel source one to ten, zero drives nothing
// - channel destination selector, default one hundred
// - digital output terminal carries a chosen channel
// - evaluate every 2 ms, inputs latched together
// - steps evaluated in ascending order each tick
// - all five channels updated at once
// - clear command holds all timers at zero
package cls_pkg;
  localparam int N_STEP = 10;
  localparam int N_CH = 5;
  localparam int CNT_W = 19;
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int TICK_MS = 2;
  localparam int HUNDREDTH_MS = 10;
  localparam int TICKS_PER_HUNDREDTH = HUNDREDTH_MS / TICK_MS;
  localparam logic [15:0] TIME_MAX = 16'hEA60;

  localparam logic [7:0] STEP_BASE = 8'h00;
  localparam logic [7:0] CH_BASE = 8'h80;
  localparam logic [7:0] STATUS_OFS = 8'hA0;
  localparam logic [7:0] MON_SEL_OFS = 8'hA4;
  localparam logic [7:0] MON_VAL_OFS = 8'hA8;
  localparam logic [7:0] DOUT_SEL_OFS = 8'hAC;

  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_TTYPE_LSB = 4;
  localparam int CFG_SEL1_LSB = 8;
  localparam int CFG_SEL2_LSB = 16;
  localparam int CH_SRC_LSB = 0;
  localparam int CH_DEST_LSB = 16;
  localparam int DEST_W = 11;

  localparam logic [31:0] CFG_MASK = 32'h001F_1F7F;
  localparam logic [31:0] CH_MASK = 32'h07FF_000F;
  localparam logic [31:0] DOUT_MASK = 32'h7777_7777;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [15:0] TIME_RST = 16'h0000;
  localparam logic [31:0] CH_RST = 32'h0064_0000;
  localparam logic [3:0] MON_SEL_RST = 4'h1;
  localparam logic [31:0] DOUT_SEL_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FN_NONE, FN_THRU, FN_AND, FN_OR, FN_XOR, FN_SET_FF, FN_RESET_FF, FN_RISE, FN_FALL, FN_BOTH
  } cls_func_t;

  typedef enum logic [2:0] {
    TM_NONE, TM_ON_DELAY, TM_OFF_DELAY, TM_ONE_SHOT, TM_RETRIG, TM_PULSE
  } cls_timer_t;

  typedef struct packed {
    logic ff;
    logic in_prev;
    logic tin_prev;
    logic tout;
    logic [CNT_W-1:0] cnt;
  } cls_step_st_t;
endpackage : cls_pkg

// File: pkg/cls_step_if.sv
/*
  carrier between the sequencer and the step evaluator.
  assumes one step is presented per clock while the sequencer is busy.
*/
`timescale 1ns/1ps
interface cls_step_if;
  logic [3:0] func;
  logic [2:0] ttype;
  logic [cls_pkg::CNT_W-1:0] per;
  logic in1;
  logic in2;
  logic clr;
  cls_pkg::cls_step_st_t cur;
  cls_pkg::cls_step_st_t nxt;
  modport eval (input func, input ttype, input per, input in1, input in2, input clr, input cur, output nxt);
  modport ctrl (output func, output ttype, output per, output in1, output in2, output clr, output cur, input nxt);
endinterface : cls_step_if

// File: rtl/cls_step_eval.sv
/*
  next state of one step: logic function, then general-purpose timer.
  assumes it is called once per processing tick for each step.
*/
`timescale 1ns/1ps
module cls_step_eval (
  cls_step_if.eval sif
);
  logic lo;
  logic started;
  logic [cls_pkg::CNT_W-1:0] inc;

  always_comb begin
    sif.nxt = sif.cur;
    inc = cls_pkg::CNT_W'(sif.cur.cnt + 1'b1);
    unique case (cls_pkg::cls_func_t'(sif.func))
      cls_pkg::FN_THRU: lo = sif.in1;
      cls_pkg::FN_AND: lo = sif.in1 & sif.in2;
      cls_pkg::FN_OR: lo = sif.in1 | sif.in2;
      cls_pkg::FN_XOR: lo = sif.in1 ^ sif.in2;
      cls_pkg::FN_SET_FF: lo = sif.in1 | (~sif.in2 & sif.cur.ff);
      cls_pkg::FN_RESET_FF: lo = ~sif.in2 & (sif.in1 | sif.cur.ff);
      cls_pkg::FN_RISE: lo = sif.in1 & ~sif.cur.in_prev;
      cls_pkg::FN_FALL: lo = ~sif.in1 & sif.cur.in_prev;
      cls_pkg::FN_BOTH: lo = sif.in1 ^ sif.cur.in_prev;
      default: lo = 1'b0;
    endcase
    sif.nxt.ff = lo;
    sif.nxt.in_prev = sif.in1;
    // logic result drives the timer
    started = lo & ~sif.cur.tin_prev;
    sif.nxt.tin_prev = lo;
    unique case (cls_pkg::cls_timer_t'(sif.ttype))
      cls_pkg::TM_ON_DELAY: begin
        if (!lo || started) begin
          sif.nxt.cnt = '0;
        end else if (sif.cur.cnt < sif.per) begin
          sif.nxt.cnt = inc;
        end
        sif.nxt.tout = lo & (sif.nxt.cnt >= sif.per);
      end
      cls_pkg::TM_OFF_DELAY: begin
        if (lo) begin
          sif.nxt.tout = 1'b1;
          sif.nxt.cnt = '0;
        end else if (sif.cur.tout) begin
          if (sif.cur.cnt >= sif.per) begin
            sif.nxt.tout = 1'b0;
            sif.nxt.cnt = '0;
          end else begin
            sif.nxt.cnt = inc;
          end
        end
      end
      cls_pkg::TM_ONE_SHOT, cls_pkg::TM_RETRIG: begin
        if (started && (sif.ttype == cls_pkg::TM_RETRIG || !sif.cur.tout)) begin
          sif.nxt.tout = (sif.per != '0);
          sif.nxt.cnt = '0;
        end else if (sif.cur.tout) begin
          if (inc >= sif.per) begin
            sif.nxt.tout = 1'b0;
            sif.nxt.cnt = '0;
          end else begin
            sif.nxt.cnt = inc;
          end
        end
      end
      cls_pkg::TM_PULSE: begin
        if (!lo) begin
          sif.nxt.tout = 1'b0;
          sif.nxt.cnt = '0;
        end else if (started) begin
          sif.nxt.tout = 1'b1;
          sif.nxt.cnt = '0;
        end else if (inc >= sif.per) begin
          sif.nxt.tout = ~sif.cur.tout;
          sif.nxt.cnt = '0;
        end else begin
          sif.nxt.cnt = inc;
        end
      end
      default: begin
        sif.nxt.tout = lo;
        sif.nxt.cnt = '0;
      end
    endcase
    if (sif.clr) begin
      sif.nxt.cnt = '0;
      if (sif.ttype != cls_pkg::TM_NONE && sif.ttype != cls_pkg::TM_ON_DELAY) begin
        sif.nxt.tout = 1'b0;
      end else begin
        sif.nxt.tout = (sif.ttype == cls_pkg::TM_ON_DELAY) ? lo & (sif.per == '0) : sif.nxt.tout;
      end
    end
  end
endmodule : cls_step_eval

// File: rtl/cls_top.sv
/*
  custom logic step sequencer: ten steps, five output channels, register slave.
  assumes an AXI4-Lite master on SYS_CLK and asynchronous terminal inputs.
*/
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module cls_top #(
  parameter int N_EXT = 8,
  parameter int N_DOUT = 2,
  parameter int TICK_CYCLES = cls_pkg::CLK_FREQ_HZ / 1000 * cls_pkg::TICK_MS
) (
  input wire logic SYS_CLK,
  input wire logic RESETN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [N_EXT-1:0] EXT_IN,
  input wire logic CLEAR_ALL_STEP_TIMERS,
  output logic [cls_pkg::N_CH-1:0] LOGIC_OUT_CHANNEL,
  output logic [cls_pkg::N_CH*cls_pkg::DEST_W-1:0] LOGIC_OUT_DEST,
  output logic [N_DOUT-1:0] GENERAL_DIGITAL_OUTPUT_TERMINAL
);
  localparam int N_STEP = cls_pkg::N_STEP;
  localparam int N_CH = cls_pkg::N_CH;
  localparam int DIV_W = $clog2(TICK_CYCLES);

  typedef struct packed {
    logic [N_EXT-1:0] ext_s1;
    logic [N_EXT-1:0] ext_s2;
    logic [N_EXT-1:0] ext_lat;
    logic clr_s1;
    logic clr_s2;
    logic [DIV_W-1:0] div;
    logic tick;
    logic busy;
    logic [3:0] idx;
    logic done;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [N_STEP-1:0][31:0] cfg;
    logic [N_STEP-1:0][15:0] tim;
    logic [N_CH-1:0][31:0] ch;
    logic [3:0] mon_sel;
    logic [31:0] dout_sel;
    cls_pkg::cls_step_st_t [N_STEP-1:0] step;
    logic [N_CH-1:0] chan_out;
    logic [N_DOUT-1:0] dout;
  } cls_top_st_t;

  cls_top_st_t q;
  cls_top_st_t d;
  logic [N_STEP-1:0] res;

  cls_step_if sif ();

  cls_step_eval u_eval (
    .sif(sif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // 0 off, 1..10 step results, 11.. latched terminal inputs
  function automatic logic pick(input logic [4:0] sel, input logic [N_STEP-1:0] r, input logic [N_EXT-1:0] e);
    logic v;
    v = 1'b0;
    for (int i = 0; i < N_STEP; i++) begin
      if (sel == 5'(i + 1)) v = r[i];
    end
    for (int j = 0; j < N_EXT; j++) begin
      if (sel == 5'(N_STEP + 1 + j)) v = e[j];
    end
    return v;
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st,
                                        input logic [31:0] mask);
    logic [31:0] bm;
    bm = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}} & mask;
    return (old & ~bm) | (wd & bm);
  endfunction : merge

  always_comb begin
    for (int i = 0; i < N_STEP; i++) begin
      res[i] = q.step[i].tout;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step presented to the evaluator

  always_comb begin
    sif.func = q.cfg[q.idx][cls_pkg::CFG_FUNC_LSB +: 4];
    sif.ttype = q.cfg[q.idx][cls_pkg::CFG_TTYPE_LSB +: 3];
    // hundredths of a second to 2 ms ticks
    sif.per = cls_pkg::CNT_W'(cls_pkg::CNT_W'(q.tim[q.idx]) * cls_pkg::CNT_W'(cls_pkg::TICKS_PER_HUNDREDTH));
    sif.in1 = pick(q.cfg[q.idx][cls_pkg::CFG_SEL1_LSB +: 5], res, q.ext_lat);
    sif.in2 = pick(q.cfg[q.idx][cls_pkg::CFG_SEL2_LSB +: 5], res, q.ext_lat);
    sif.clr = q.clr_s2;
    sif.cur = q.step[q.idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0] rd;
    logic ok;
    logic [5:0] wa;
    logic [5:0] ra;
    logic [2:0] ts;
    logic [15:0] tv;
    rd = 32'h0000_0000;
    ok = 1'b0;
    wa = q.aw_addr[7:2];
    ra = S_AXI_ARADDR[7:2];
    ts = 3'h0;
    tv = 16'h0000;
    d = q;
    d.ext_s1 = EXT_IN;
    d.ext_s2 = q.ext_s1;
    d.clr_s1 = CLEAR_ALL_STEP_TIMERS;
    d.clr_s2 = q.clr_s1;
    d.tick = 1'b0;
    d.done = 1'b0;

    // 2 ms tick divider
    if (q.div == DIV_W'(TICK_CYCLES - 1)) begin
      d.div = '0;
      d.tick = 1'b1;
    end else begin
      d.div = DIV_W'(q.div + 1'b1);
    end

    if (q.tick) begin
      d.ext_lat = q.ext_s2;
      d.busy = 1'b1;
      d.idx = 4'h0;
    end else if (q.busy) begin
      d.step[q.idx] = sif.nxt;
      if (q.idx == 4'(N_STEP - 1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end else begin
        d.idx = 4'(q.idx + 1'b1);
      end
    end

    // channels and terminals change together after the last step
    if (q.done) begin
      for (int c = 0; c < N_CH; c++) begin
        d.chan_out[c] = 1'b0;
        for (int i = 0; i < N_STEP; i++) begin
          if (q.ch[c][cls_pkg::CH_SRC_LSB +: 4] == 4'(i + 1)) d.chan_out[c] = res[i];
        end
      end
      for (int t = 0; t < N_DOUT; t++) begin
        d.dout[t] = 1'b0;
        for (int c = 0; c < N_CH; c++) begin
          if (q.dout_sel[4 * t +: 3] == 3'(c + 1)) d.dout[t] = d.chan_out[c];
        end
      end
    end

    // write channel
    if (S_AXI_AWVALID && !q.aw_full) begin
      d.aw_full = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !q.w_full) begin
      d.w_full = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    if (q.bvalid && S_AXI_BREADY) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = cls_pkg::RESP_OKAY;
      if (wa < 6'(N_STEP * 2)) begin
        if (wa[0]) begin
          tv = 16'(merge(32'(q.tim[wa[4:1]]), q.w_data, q.w_strb, 32'h0000_FFFF));
          d.tim[wa[4:1]] = (tv > cls_pkg::TIME_MAX) ? cls_pkg::TIME_MAX : tv;
        end else begin
          d.cfg[wa[4:1]] = merge(q.cfg[wa[4:1]], q.w_data, q.w_strb, cls_pkg::CFG_MASK);
        end
      end else if (wa >= cls_pkg::CH_BASE[7:2] && wa < 6'(cls_pkg::CH_BASE[7:2] + N_CH)) begin
        d.ch[3'(wa - cls_pkg::CH_BASE[7:2])] =
          merge(q.ch[3'(wa - cls_pkg::CH_BASE[7:2])], q.w_data, q.w_strb, cls_pkg::CH_MASK);
      end else if (wa == cls_pkg::MON_SEL_OFS[7:2]) begin
        d.mon_sel = 4'(merge(32'(q.mon_sel), q.w_data, q.w_strb, 32'h0000_000F));
      end else if (wa == cls_pkg::DOUT_SEL_OFS[7:2]) begin
        d.dout_sel = merge(q.dout_sel, q.w_data, q.w_strb, cls_pkg::DOUT_MASK);
      end else if (wa != cls_pkg::STATUS_OFS[7:2] && wa != cls_pkg::MON_VAL_OFS[7:2]) begin
        d.bresp = cls_pkg::RESP_SLVERR;
      end
    end

    // read channel
    if (ra < 6'(N_STEP * 2)) begin
      ok = 1'b1;
      rd = ra[0] ? 32'(q.tim[ra[4:1]]) : q.cfg[ra[4:1]];
    end else if (ra >= cls_pkg::CH_BASE[7:2] && ra < 6'(cls_pkg::CH_BASE[7:2] + N_CH)) begin
      ok = 1'b1;
      rd = q.ch[3'(ra - cls_pkg::CH_BASE[7:2])];
    end else if (ra == cls_pkg::STATUS_OFS[7:2]) begin
      ok = 1'b1;
      rd = {17'h0_0000, q.chan_out, res};
    end else if (ra == cls_pkg::MON_SEL_OFS[7:2]) begin
      ok = 1'b1;
      rd = 32'(q.mon_sel);
    end else if (ra == cls_pkg::MON_VAL_OFS[7:2]) begin
      ok = 1'b1;
      for (int i = 0; i < N_STEP; i++) begin
        if (q.mon_sel == 4'(i + 1)) rd = 32'(q.step[i].cnt);
      end
    end else if (ra == cls_pkg::DOUT_SEL_OFS[7:2]) begin
      ok = 1'b1;
      rd = q.dout_sel;
    end
    if (S_AXI_ARVALID && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = ok ? cls_pkg::RESP_OKAY : cls_pkg::RESP_SLVERR;
    end else if (q.rvalid && S_AXI_RREADY) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.cfg <= {N_STEP{cls_pkg::CFG_RST}};
      q.tim <= {N_STEP{cls_pkg::TIME_RST}};
      q.ch <= {N_CH{cls_pkg::CH_RST}};
      q.mon_sel <= cls_pkg::MON_SEL_RST;
      q.dout_sel <= cls_pkg::DOUT_SEL_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign S_AXI_AWREADY = !q.aw_full;
  assign S_AXI_WREADY = !q.w_full;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = !q.rvalid;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RDATA = q.rdata;
  assign S_AXI_RRESP = q.rresp;
  assign LOGIC_OUT_CHANNEL = q.chan_out;
  assign GENERAL_DIGITAL_OUTPUT_TERMINAL = q.dout;

  always_comb begin
    for (int c = 0; c < N_CH; c++) begin
      LOGIC_OUT_DEST[c * cls_pkg::DEST_W +: cls_pkg::DEST_W] = q.ch[c][cls_pkg::CH_DEST_LSB +: cls_pkg::DEST_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_tick;
    q.tick;
  endsequence
  sequence s_stepping;
    q.busy && q.idx < 4'(N_STEP - 1);
  endsequence
  sequence s_last_step;
    q.busy && q.idx == 4'(N_STEP - 1);
  endsequence

  chk_tick_latch: assert property (s_tick |=> q.busy && q.idx == 4'h0 && q.ext_lat == $past(q.ext_s2))
    else $error("inputs not latched at tick start");
  chk_step_order: assert property (s_stepping |=> q.busy && q.idx == 4'($past(q.idx) + 1'b1))
    else $error("steps not evaluated in ascending order");
  chk_eval_end: assert property (s_last_step |=> q.done && !q.busy ##1 !q.done)
    else $error("evaluation did not end after last step");
  chk_chan_together: assert property ($changed(q.chan_out) |-> $past(q.done))
    else $error("channel changed outside the update point");
  chk_set_ff: assert property (q.busy && !q.tick && sif.func == cls_pkg::FN_SET_FF && sif.in1
                               |=> q.step[$past(q.idx)].ff)
    else $error("set-priority flip-flop not set");
  chk_reset_ff: assert property (q.busy && !q.tick && sif.func == cls_pkg::FN_RESET_FF && sif.in2
                                 |=> !q.step[$past(q.idx)].ff)
    else $error("reset-priority flip-flop not reset");
  chk_on_delay_drop: assert property (q.busy && sif.ttype == cls_pkg::TM_ON_DELAY && !sif.nxt.ff
                                      |=> !q.step[$past(q.idx)].tout)
    else $error("on-delay output did not drop");
  chk_off_delay_rise: assert property (q.busy && sif.ttype == cls_pkg::TM_OFF_DELAY && sif.nxt.ff
                                       |=> q.step[$past(q.idx)].tout)
    else $error("off-delay output did not rise");
  chk_clear_zero: assert property (q.busy && q.clr_s2 |=> q.step[$past(q.idx)].cnt == '0)
    else $error("timer not held at zero during clear");
  chk_time_range: assert property (q.busy |-> q.tim[q.idx] <= cls_pkg::TIME_MAX)
    else $error("time setting above maximum");
  chk_chan_silent: assert property (q.done && q.ch[0][3:0] == 4'h0 |=> !q.chan_out[0])
    else $error("unassigned channel drives a signal");
endmodule : cls_top

// File: bench/cls_seq_model.sv
/*
  far-side model: sequence processor inputs and digital output terminals.
  assumes it sees the block's channel, destination and terminal outputs only.
*/
`timescale 1ns/1ps
module cls_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [cls_pkg::N_CH-1:0] chan,
  input wire logic [cls_pkg::N_CH*cls_pkg::DEST_W-1:0] dest,
  input wire logic [1:0] term,
  output logic [cls_pkg::N_CH-1:0] seen_chan,
  output logic [1:0] seen_term
);
  ////////////////////////////////////////////////////////////////////////////
  // sees step results only through channels and terminals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_chan <= '0;
      seen_term <= '0;
    end else begin
      seen_chan <= chan;
      seen_term <= term;
    end
  end
endmodule : cls_seq_model

// File: bench/cls_bench.sv
/*
  self-checking bench of the step timer block over AXI4-Lite.
  assumes a short tick of 20 cycles and the hand-over register map.
*/
`timescale 1ns/1ps
module cls_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] ext = 8'h00;
  logic clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, term, seen_term;
  logic [31:0] rdata;
  logic [cls_pkg::N_CH-1:0] chan, seen_chan;
  logic [cls_pkg::N_CH*cls_pkg::DEST_W-1:0] dest;
  logic [3:0] ex [6] = '{4'h c, 4'h4, 4'h e, 4'h8, 4'h8, 4'h8};
  logic [1:0] pat [6] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2, 2'h0};
  logic [5:0] es = 6'h0f;
  logic [5:0] er = 6'h03;
  int err_count = 0;
  int checks = 0;

  always #20 clk = ~clk;

  cls_top #(.N_EXT(8), .N_DOUT(2), .TICK_CYCLES(20)) i_dut (
    .SYS_CLK(clk), .RESETN(rst_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .EXT_IN(ext), .CLEAR_ALL_STEP_TIMERS(clr), .LOGIC_OUT_CHANNEL(chan),
    .LOGIC_OUT_DEST(dest), .GENERAL_DIGITAL_OUTPUT_TERMINAL(term)
  );

  cls_seq_model i_far (.clk(clk), .rst_n(rst_n), .chan(chan), .dest(dest), .term(term),
    .seen_chan(seen_chan), .seen_term(seen_term));

  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] e, input logic [31:0] a);
    checks++;
    if (a !== e) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk

  task tmo;
    err_count++;
    $display("BAD t=%0t exp=%h got=%h no answer", $time, 1, 0);
    wrap_up();
  endtask : tmo

  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    logic ta, tw;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (bvalid === 1'b1) break;
      ta = (awready === 1'b1);
      tw = (wready === 1'b1);
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (n == 100) tmo();
    chk({30'h0, e}, {30'h0, bresp});
    @(posedge clk);
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er2);
    int n;
    logic tk;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge clk);
      if (rvalid === 1'b1) break;
      tk = (arready === 1'b1);
      @(posedge clk);
      if (tk) arvalid <= 1'b0;
    end
    if (n == 100) tmo();
    chk(e, rdata);
    chk({30'h0, er2}, {30'h0, rresp});
    @(posedge clk);
    rready <= 1'b0;
  endtask : axi_rd

  // waits n cycles, looks at channel i between edges, ends on a rising edge
  task probe(input int n, input int i, input logic e);
    repeat (n - 1) @(posedge clk);
    @(negedge clk);
    chk({31'h0, e}, {31'h0, chan[i]});
    @(posedge clk);
  endtask : probe

  // channels fed by the same step never differ
  always @(negedge clk) begin
    if (rst_n && chan[0] !== chan[4]) begin
      err_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, chan[0], chan[4]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int c = 0; c < cls_pkg::N_CH; c++) begin
      chk(32'h0000_0064, {21'h0, dest[c*cls_pkg::DEST_W +: cls_pkg::DEST_W]});
    end
    axi_rd(8'h8c, cls_pkg::CH_RST, cls_pkg::RESP_OKAY);
    axi_rd(8'ha4, {28'h0, cls_pkg::MON_SEL_RST}, cls_pkg::RESP_OKAY);
    axi_rd(8'hb0, 32'h0000_0000, cls_pkg::RESP_SLVERR);
    axi_wr(8'hb0, 32'h0000_0001, cls_pkg::RESP_SLVERR);
    axi_wr(8'h4c, 32'h0000_ffff, cls_pkg::RESP_OKAY);
    axi_rd(8'h4c, {16'h0, cls_pkg::TIME_MAX}, cls_pkg::RESP_OKAY);
    $display("test reset and map done");
    axi_wr(8'h00, 32'h000c_0b05, cls_pkg::RESP_OKAY);
    axi_wr(8'h08, 32'h000c_0b06, cls_pkg::RESP_OKAY);
    axi_wr(8'h14, 32'h0000_0001, cls_pkg::RESP_OKAY);
    axi_wr(8'h80, 32'h0123_0001, cls_pkg::RESP_OKAY);
    axi_wr(8'h84, 32'h0064_0002, cls_pkg::RESP_OKAY);
    axi_wr(8'h88, 32'h0064_0003, cls_pkg::RESP_OKAY);
    axi_wr(8'h90, 32'h0064_0001, cls_pkg::RESP_OKAY);
    axi_wr(8'hac, 32'h0000_0012, cls_pkg::RESP_OKAY);
    for (int p = 0; p < 6; p++) begin
      ext[1:0] <= pat[p];
      repeat (69) @(posedge clk);
      @(negedge clk);
      chk({31'h0, es[p]}, {31'h0, chan[0]});
      chk({31'h0, er[p]}, {31'h0, chan[1]});
      chk({31'h0, 1'b0}, {31'h0, chan[3]});
      chk({30'h0, es[p], er[p]}, {30'h0, seen_term});
      @(posedge clk);
    end
    chk(32'h0000_0123, {21'h0, dest[10:0]});
    $display("test flip-flops done");
    for (int t = 0; t < 6; t++) begin
      axi_wr(8'h10, 32'h0000_0d01 | (t << 4), cls_pkg::RESP_OKAY);
      ext[2] <= 1'b1;
      probe(50, 2, ex[t][3]);
      probe(100, 2, ex[t][2]);
      ext[2] <= 1'b0;
      probe(50, 2, ex[t][1]);
      probe(100, 2, ex[t][0]);
      repeat (150) @(posedge clk);
    end
    $display("test timer types done");
    for (int t = 3; t < 5; t++) begin
      axi_wr(8'h10, 32'h0000_0d01 | (t << 4), cls_pkg::RESP_OKAY);
      ext[2] <= 1'b1;
      repeat (60) @(posedge clk);
      ext[2] <= 1'b0;
      repeat (40) @(posedge clk);
      ext[2] <= 1'b1;
      probe(70, 2, t == 4);
      ext[2] <= 1'b0;
      repeat (250) @(posedge clk);
    end
    $display("test retrigger done");
    axi_wr(8'h10, 32'h0000_0d11, cls_pkg::RESP_OKAY);
    clr <= 1'b1;
    ext[2] <= 1'b1;
    probe(150, 2, 1'b0);
    clr <= 1'b0;
    probe(50, 2, 1'b0);
    probe(100, 2, 1'b1);
    ext[2] <= 1'b0;
    probe(50, 2, 1'b0);
    $display("test clear done");
    wrap_up();
  end
endmodule : cls_bench
